/* eptb_params.svh */
`ifndef EPTB_PARAMS_SVH
`define EPTB_PARAMS_SVH
// Register byte offsets
`define EPTB_OFS_CTRL 12'h000
`define EPTB_OFS_CFG 12'h004
`define EPTB_OFS_NV 12'h008
`define EPTB_OFS_DIVH 12'h00c
`define EPTB_OFS_DIVL 12'h010
`define EPTB_OFS_DIVHNV 12'h014
`define EPTB_OFS_DIVLNV 12'h018
`define EPTB_OFS_REQ 12'h01c
`define EPTB_OFS_STAT 12'h020
// Field positions
`define EPTB_SEC_BIT 4
`define EPTB_DSEC_BIT 7
`define EPTB_LAT_BIT 0
`define EPTB_PGM_BIT 1
`define EPTB_STOP_BIT 2
// Reset values
`define EPTB_NV_RST 8'hf0
`define EPTB_DIVH_RST 8'h80
`define EPTB_DIVL_RST 8'hac
// Array map
`define EPTB_ARR_BASE 16'h0800
`define EPTB_ARR_TOP 16'h09ff
`define EPTB_SEC_LO 16'h08f0
`define EPTB_SEC_HI 16'h08ff
// Program cycle tick count; the cycle ends on the tick after the count reaches it
`define EPTB_PE_TICKS 8'h10
`define EPTB_RESP_OKAY 2'b00
`define EPTB_RESP_SLVERR 2'b10
`endif

/* eptb_pkg.sv */
package eptb_pkg;
  typedef enum logic [1:0] {EPTB_BYTE_PGM, EPTB_BYTE_ERA, EPTB_BLOCK_ERA,
                            EPTB_BULK_ERA} eptb_mode_e;
  typedef enum logic [1:0] {EPTB_TGT_ARRAY, EPTB_TGT_NV, EPTB_TGT_DIVH, EPTB_TGT_DIVL} eptb_tgt_e;
  typedef enum logic [1:0] {EPTB_IDLE, EPTB_RUN, EPTB_HALT} eptb_state_e;
endpackage

/* eptb_top.sv */
// The placing of the registers and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ns
`include "eptb_params.svh"
module eptb_top #(
  parameter int DIV_W = 11
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Reference clock enable and low-power modes
  input wire logic ref_clk_en,
  input wire logic wait_mode,
  input wire logic stop_mode,
  // AXI4-Lite write
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Status toward the array
  output logic timebase_tick,
  output logic high_voltage_on,
  output logic array_access_block,
  output logic request_refused
);
  // Registers
  logic [7:0] array_protect_config;
  logic [7:0] timebase_divider_high;
  logic [7:0] timebase_divider_low;
  // Factory contents of the nonvolatile stores; reset leaves them alone
  logic [7:0] array_protect_nonvolatile = `EPTB_NV_RST;
  logic [7:0] timebase_divider_high_nonvolatile = `EPTB_DIVH_RST;
  logic [7:0] timebase_divider_low_nonvolatile = `EPTB_DIVL_RST;
  logic bus_latch_control;
  logic program_erase_enable;
  logic [15:0] latch_addr;
  logic [7:0] latch_data;
  eptb_pkg::eptb_mode_e latch_mode;
  eptb_pkg::eptb_tgt_e latch_tgt;
  logic latch_valid;
  eptb_pkg::eptb_state_e pe_state;
  logic [7:0] pe_ticks;
  logic [DIV_W-1:0] tb_count;
  logic [DIV_W-1:0] timebase_divisor;
  logic [7:0] array_mem [0:511];
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic aw_have;
  logic w_have;
  logic wr_go;
  logic wr_ok;
  logic [31:0] next_rdata;
  logic rd_ok;
  logic stop_seen;
  logic array_security_bit;
  logic [3:0] block_protect_bits;
  logic divider_lock_disable;
  logic req_allowed;

  // New contents of one nonvolatile byte: program only clears bits
  function automatic logic [7:0] eptb_cell(input logic [7:0] old,
                                           input eptb_pkg::eptb_mode_e m,
                                           input logic [7:0] d);
    eptb_cell = (m == eptb_pkg::EPTB_BYTE_PGM) ? (old & d) : 8'hff;
  endfunction

  // Permission check of one request
  function automatic logic eptb_allow(input logic [15:0] a, input eptb_pkg::eptb_mode_e m,
                                      input eptb_pkg::eptb_tgt_e t, input logic [7:0] cfg,
                                      input logic dsec);
    logic sec_on;
    logic [1:0] blk;
    sec_on = ~cfg[`EPTB_SEC_BIT];
    blk = a[8:7];
    eptb_allow = 1'b0;
    if (t == eptb_pkg::EPTB_TGT_NV) begin
      // Erasing would bring the security bit back to 1, so it is refused once secured
      eptb_allow = (m == eptb_pkg::EPTB_BYTE_PGM)
                   || (m == eptb_pkg::EPTB_BYTE_ERA && !sec_on);
    end else if (t != eptb_pkg::EPTB_TGT_ARRAY) begin
      eptb_allow = dsec && ((m == eptb_pkg::EPTB_BYTE_PGM)
                            || (m == eptb_pkg::EPTB_BYTE_ERA));
    end else if (a < `EPTB_ARR_BASE || a > `EPTB_ARR_TOP) begin
      eptb_allow = 1'b0;
    end else if (cfg[blk]) begin
      eptb_allow = 1'b0;
    end else if (sec_on && a >= `EPTB_SEC_LO && a <= `EPTB_SEC_HI) begin
      eptb_allow = 1'b0;
    end else if (sec_on) begin
      eptb_allow = (m == eptb_pkg::EPTB_BYTE_PGM) || (m == eptb_pkg::EPTB_BYTE_ERA);
    end else begin
      eptb_allow = 1'b1;
    end
  endfunction

  // Field views
  assign array_security_bit = array_protect_config[`EPTB_SEC_BIT];
  assign block_protect_bits = array_protect_config[3:0];
  assign divider_lock_disable = timebase_divider_high[`EPTB_DSEC_BIT];
  assign timebase_divisor = {timebase_divider_high[DIV_W-9:0], timebase_divider_low};
  assign req_allowed = eptb_allow(latch_addr, latch_mode, latch_tgt,
                                  {array_protect_config[7:5], array_security_bit,
                                   block_protect_bits}, divider_lock_disable);

  // Write address and data capture, either order
  assign wr_go = aw_have && w_have && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_have <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_go) begin
        w_have <= 1'b0;
      end
    end
  end

  // Ready signals
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_have && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_have && !(s_axi_wvalid && s_axi_wready);
    end
  end

  // Decode of mapped offsets for the write response
  always_comb begin
    unique case (aw_addr)
      `EPTB_OFS_CTRL, `EPTB_OFS_CFG, `EPTB_OFS_NV, `EPTB_OFS_DIVH, `EPTB_OFS_DIVL,
      `EPTB_OFS_DIVHNV, `EPTB_OFS_DIVLNV, `EPTB_OFS_REQ, `EPTB_OFS_STAT: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `EPTB_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? `EPTB_RESP_OKAY : `EPTB_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Configuration, inert upper bits writable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      array_protect_config <= `EPTB_NV_RST;
    end else if (stop_seen) begin
      array_protect_config <= array_protect_nonvolatile;
    end else if (wr_go && aw_addr == `EPTB_OFS_CFG && w_strb[0]) begin
      array_protect_config[7:5] <= w_data[7:5];
    end
  end

  // Reload of configuration from option byte after reset release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stop_seen <= 1'b1;
    end else begin
      stop_seen <= 1'b0;
    end
  end

  // Latch and program enable control
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bus_latch_control <= 1'b0;
      program_erase_enable <= 1'b0;
      latch_mode <= eptb_pkg::EPTB_BYTE_PGM;
    end else begin
      if (wr_go && aw_addr == `EPTB_OFS_CTRL && w_strb[0]) begin
        if (w_data[`EPTB_PGM_BIT] && bus_latch_control && latch_valid) begin
          program_erase_enable <= 1'b1;
        end else if (!w_data[`EPTB_PGM_BIT] && pe_state == eptb_pkg::EPTB_IDLE) begin
          program_erase_enable <= 1'b0;
        end
        if (w_data[`EPTB_LAT_BIT]) begin
          bus_latch_control <= 1'b1;
        end else if (!program_erase_enable) begin
          bus_latch_control <= 1'b0;
        end
        if (!program_erase_enable) begin
          latch_mode <= eptb_pkg::eptb_mode_e'(w_data[5:4]);
        end
      end else if (pe_state == eptb_pkg::EPTB_RUN && pe_ticks == `EPTB_PE_TICKS
                   && timebase_tick) begin
        program_erase_enable <= 1'b0;
      end else if (stop_mode && pe_state == eptb_pkg::EPTB_IDLE && !bus_latch_control) begin
        program_erase_enable <= 1'b0;
      end
    end
  end

  // Latched request address and data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      latch_addr <= 16'h0000;
      latch_data <= 8'h00;
      latch_tgt <= eptb_pkg::EPTB_TGT_ARRAY;
      latch_valid <= 1'b0;
    end else if (!bus_latch_control) begin
      latch_valid <= 1'b0;
    end else if (wr_go && aw_addr == `EPTB_OFS_REQ && !program_erase_enable) begin
      latch_addr <= w_data[15:0];
      latch_data <= w_data[23:16];
      latch_tgt <= eptb_pkg::eptb_tgt_e'(w_data[25:24]);
      latch_valid <= 1'b1;
    end
  end

  // Program and erase sequence with stop handling
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pe_state <= eptb_pkg::EPTB_IDLE;
      pe_ticks <= 8'h00;
      request_refused <= 1'b0;
    end else begin
      request_refused <= 1'b0;
      unique case (pe_state)
        eptb_pkg::EPTB_IDLE: begin
          if (program_erase_enable && latch_valid && !stop_mode) begin
            if (req_allowed) begin
              pe_state <= eptb_pkg::EPTB_RUN;
              pe_ticks <= 8'h00;
            end else begin
              request_refused <= !(wr_go && aw_addr == `EPTB_OFS_CTRL);
            end
          end
        end
        eptb_pkg::EPTB_RUN: begin
          if (stop_mode) begin
            if (bus_latch_control && program_erase_enable) begin
              pe_state <= eptb_pkg::EPTB_HALT;
            end else begin
              pe_state <= eptb_pkg::EPTB_IDLE;
            end
          end else if (timebase_tick) begin
            if (pe_ticks == `EPTB_PE_TICKS) begin
              pe_state <= eptb_pkg::EPTB_IDLE;
            end else begin
              pe_ticks <= pe_ticks + 8'h01;
            end
          end
        end
        eptb_pkg::EPTB_HALT: begin
          if (!stop_mode) begin
            pe_state <= eptb_pkg::EPTB_RUN;
            pe_ticks <= 8'h00;
          end
        end
      endcase
    end
  end

  // Nonvolatile stores and array contents updated at sequence end
  always_ff @(posedge aclk) begin
    if (aresetn && pe_state == eptb_pkg::EPTB_RUN && timebase_tick && !stop_mode
        && pe_ticks == `EPTB_PE_TICKS) begin
      unique case (latch_tgt)
        eptb_pkg::EPTB_TGT_NV: begin
          array_protect_nonvolatile <= eptb_cell(array_protect_nonvolatile, latch_mode,
                                                 latch_data);
        end
        eptb_pkg::EPTB_TGT_DIVH: begin
          timebase_divider_high_nonvolatile <= eptb_cell(timebase_divider_high_nonvolatile,
                                                         latch_mode, latch_data);
        end
        eptb_pkg::EPTB_TGT_DIVL: begin
          timebase_divider_low_nonvolatile <= eptb_cell(timebase_divider_low_nonvolatile,
                                                        latch_mode, latch_data);
        end
        eptb_pkg::EPTB_TGT_ARRAY: begin
          if (latch_mode == eptb_pkg::EPTB_BYTE_PGM) begin
            array_mem[latch_addr[8:0]] <= array_mem[latch_addr[8:0]] & latch_data;
          end else if (latch_mode == eptb_pkg::EPTB_BYTE_ERA) begin
            array_mem[latch_addr[8:0]] <= 8'hff;
          end else begin
            for (int i = 0; i < 512; i++) begin
              if ((latch_mode == eptb_pkg::EPTB_BULK_ERA && !array_protect_config[i/128])
                  || i[8:7] == latch_addr[8:7]) begin
                array_mem[i] <= 8'hff;
              end
            end
          end
        end
      endcase
    end
  end

  // Divider registers, locked unless disable bit set and latch clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timebase_divider_high <= `EPTB_DIVH_RST;
      timebase_divider_low <= `EPTB_DIVL_RST;
    end else if (stop_seen) begin
      timebase_divider_high <= timebase_divider_high_nonvolatile;
      timebase_divider_low <= timebase_divider_low_nonvolatile;
    end else if (wr_go && w_strb[0] && !bus_latch_control && divider_lock_disable) begin
      if (aw_addr == `EPTB_OFS_DIVH) begin
        timebase_divider_high <= w_data[7:0];
      end else if (aw_addr == `EPTB_OFS_DIVL) begin
        timebase_divider_low <= w_data[7:0];
      end
    end
  end

  // Timebase divider, tick when count reaches divisor
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tb_count <= '0;
      timebase_tick <= 1'b0;
    end else begin
      timebase_tick <= 1'b0;
      if (ref_clk_en) begin
        if (tb_count + 1'b1 >= timebase_divisor) begin
          tb_count <= '0;
          timebase_tick <= 1'b1;
        end else begin
          tb_count <= tb_count + 1'b1;
        end
      end
    end
  end

  // Array side status
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      high_voltage_on <= 1'b0;
      array_access_block <= 1'b0;
    end else begin
      high_voltage_on <= (pe_state == eptb_pkg::EPTB_RUN) && !stop_mode;
      array_access_block <= pe_state != eptb_pkg::EPTB_IDLE;
    end
  end

  // Read decode
  always_comb begin
    next_rdata = 32'h0000_0000;
    rd_ok = 1'b1;
    unique case (s_axi_araddr)
      `EPTB_OFS_CTRL: next_rdata = {26'h0, latch_mode, 2'h0, program_erase_enable,
                                    bus_latch_control};
      `EPTB_OFS_CFG: next_rdata = {24'h0, array_protect_config};
      `EPTB_OFS_NV: next_rdata = {24'h0, array_protect_nonvolatile};
      `EPTB_OFS_DIVH: next_rdata = {24'h0, timebase_divider_high};
      `EPTB_OFS_DIVL: next_rdata = {24'h0, timebase_divider_low};
      `EPTB_OFS_DIVHNV: next_rdata = {24'h0, timebase_divider_high_nonvolatile};
      `EPTB_OFS_DIVLNV: next_rdata = {24'h0, timebase_divider_low_nonvolatile};
      `EPTB_OFS_REQ: next_rdata = {6'h0, latch_tgt, latch_data, latch_addr};
      `EPTB_OFS_STAT: next_rdata = {28'h0, wait_mode, latch_valid, high_voltage_on,
                                    array_access_block};
      default: rd_ok = 1'b0;
    endcase
  end

  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `EPTB_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= next_rdata;
        s_axi_rresp <= rd_ok ? `EPTB_RESP_OKAY : `EPTB_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

/* eptb_top_assertions.sv */
`timescale 1ns/1ns
module eptb_top_chk #(
  parameter int DIV_W = 11
) (
  // Clock, reset and modes
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ref_clk_en,
  input wire logic stop_mode,
  // Bus handshakes
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Array status
  input wire logic timebase_tick,
  input wire logic high_voltage_on,
  input wire logic array_access_block,
  input wire logic request_refused
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Bus answers come after each handshake and stand until taken
  chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready
                                    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped early");
  chk_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready
                                    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped early");
  chk_write_answer: assert property (s_axi_wvalid && s_axi_wready |-> ##[1:4] s_axi_bvalid)
    else $error("write answer missing");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer missing");
  // Timebase emits single pulses caused by reference enables
  chk_tick_single: assert property (timebase_tick |=> !timebase_tick)
    else $error("tick wider than one cycle");
  chk_tick_needs_ref: assert property (timebase_tick |-> $past(ref_clk_en) || $past(ref_clk_en, 2))
    else $error("tick without reference enable");
  // High voltage only inside a blocked sequence, removed in stop
  chk_hv_blocks: assert property (high_voltage_on |-> array_access_block)
    else $error("high voltage while array open");
  chk_stop_drops_hv: assert property (stop_mode |=> !high_voltage_on)
    else $error("high voltage kept in stop");

  // Main scenarios reached
  cov_tick: cover property (timebase_tick);
  cov_refused: cover property (request_refused);
  cov_stop_busy: cover property (stop_mode && array_access_block);
endmodule

bind eptb_top eptb_top_chk #(.DIV_W(DIV_W)) u_chk (.aclk(aclk), .aresetn(aresetn),
  .ref_clk_en(ref_clk_en), .stop_mode(stop_mode), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .timebase_tick(timebase_tick), .high_voltage_on(high_voltage_on),
  .array_access_block(array_access_block), .request_refused(request_refused));

/* test_eptb_top.sv */
`timescale 1ns/1ns
`include "eptb_params.svh"
module test_eptb_top;
  logic aclk, aresetn, ref_clk_en, wait_mode, stop_mode;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic timebase_tick, high_voltage_on, array_access_block, request_refused;
  logic tick_on = 1'b0;
  logic [7:0] dl;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;
  int exp_div = 0;
  int en_cnt = 0;
  int n_tick = 0;

  eptb_top #(.DIV_W(11)) DUT (.aclk(aclk), .aresetn(aresetn), .ref_clk_en(ref_clk_en),
    .wait_mode(wait_mode), .stop_mode(stop_mode), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .timebase_tick(timebase_tick),
    .high_voltage_on(high_voltage_on), .array_access_block(array_access_block),
    .request_refused(request_refused));

  // Bench clock, 4 ns period
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic test_done();
    $display("Checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Bus write: address and data offered together, each released when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    logic ad, wd, bd;
    n = 0;
    ad = 1'b0;
    wd = 1'b0;
    bd = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!bd && n < 200) begin
      @(posedge aclk);
      n++;
      if (!ad && s_axi_awready) begin ad = 1'b1; s_axi_awvalid <= 1'b0; end
      if (!wd && s_axi_wready) begin wd = 1'b1; s_axi_wvalid <= 1'b0; end
      if (s_axi_bvalid) begin bd = 1'b1; rsp = s_axi_bresp; s_axi_bready <= 1'b0; end
    end
    if (!bd) chk("write answer", 1, 0);
  endtask

  // Bus read: data and response taken at the edge rvalid is seen
  task automatic rd(input logic [11:0] a);
    int n;
    logic ad, dn;
    n = 0;
    ad = 1'b0;
    dn = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!dn && n < 200) begin
      @(posedge aclk);
      n++;
      if (!ad && s_axi_arready) begin ad = 1'b1; s_axi_arvalid <= 1'b0; end
      if (s_axi_rvalid) begin
        dn = 1'b1;
        rdv = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
      end
    end
    if (!dn) chk("read answer", 1, 0);
  endtask

  // Divisor that software derives from a reference frequency in hertz
  function automatic int div_for(input int hz);
    div_for = $rtoi(hz * 35.0e-6 + 0.5);
  endfunction

  task automatic rst(input int n);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (n) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
  endtask

  // One program or erase request; rf 2 leaves the verdict unchecked
  task automatic op(input logic [1:0] md, input logic [1:0] tg, input logic [15:0] a,
                    input logic [7:0] d, input logic [1:0] rf, input logic stp);
    int n;
    n = 0;
    wr(`EPTB_OFS_CTRL, {26'h0, md, 4'b0001});
    wr(`EPTB_OFS_REQ, {6'h0, tg, d, a});
    wr(`EPTB_OFS_CTRL, {26'h0, md, 4'b0011});
    repeat (3) @(posedge aclk);
    if (rf != 2'd2) chk("refused", rf[0], request_refused);
    if (rf != 2'd2) chk("busy", !rf[0], array_access_block);
    if (stp) begin
      stop_mode <= 1'b1;
      repeat (10) @(posedge aclk);
      chk("stop hv", 0, high_voltage_on);
      chk("stop block", 1, array_access_block);
      stop_mode <= 1'b0;
    end
    while (array_access_block !== 1'b0 && n < 8000) begin
      @(posedge aclk);
      n++;
    end
    chk("op done", 0, array_access_block);
    wr(`EPTB_OFS_CTRL, {26'h0, md, 4'b0001});
    wr(`EPTB_OFS_CTRL, 32'h0);
  endtask

  // Tick spacing in reference enables, and the run limit
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      test_done();
    end
    if (timebase_tick === 1'b1) begin
      if (tick_on && n_tick >= 2) chk("tick spacing", exp_div, en_cnt);
      if (tick_on) n_tick++;
      en_cnt = int'(ref_clk_en);
    end else begin
      en_cnt += int'(ref_clk_en);
    end
  end

  // Main sequence
  initial begin
    aresetn = 1'b0; ref_clk_en = 1'b1; wait_mode = 1'b0; stop_mode = 1'b0;
    s_axi_awaddr = 12'h000; s_axi_awvalid = 1'b0; s_axi_wdata = 32'h0; s_axi_wstrb = 4'hf;
    s_axi_wvalid = 1'b0; s_axi_bready = 1'b0; s_axi_araddr = 12'h000; s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    void'($urandom(83));
    rst(20);
    rd(`EPTB_OFS_CFG); chk("cfg reset", {24'h0, `EPTB_NV_RST}, rdv);
    rd(`EPTB_OFS_DIVH); chk("divh reset", {24'h0, `EPTB_DIVH_RST}, rdv);
    rd(`EPTB_OFS_DIVL); chk("divl reset", {24'h0, `EPTB_DIVL_RST}, rdv);
    rd(12'h040); chk("unmapped", {30'h0, `EPTB_RESP_SLVERR}, {30'h0, rsp});
    wr(12'h040, 32'h0);
    chk("wr unmapped", {30'h0, `EPTB_RESP_SLVERR}, {30'h0, rsp});
    wr(`EPTB_OFS_CFG, 32'h0f);
    rd(`EPTB_OFS_CFG); chk("cfg write", 32'h10, rdv);
    wr(`EPTB_OFS_CFG, 32'he0);
    rd(`EPTB_OFS_CFG); chk("cfg spare", 32'hf0, rdv);
    dl = 8'(div_for(100000 + int'($urandom % 1000000)));
    wr(`EPTB_OFS_DIVL, {24'h0, dl});
    wr(`EPTB_OFS_DIVH, 32'h80);
    rd(`EPTB_OFS_DIVL); chk("divl write", {24'h0, dl}, rdv);
    wr(`EPTB_OFS_CTRL, 32'h1);
    wr(`EPTB_OFS_DIVL, {24'h0, dl ^ 8'h01});
    rd(`EPTB_OFS_DIVL); chk("divl latched", {24'h0, dl}, rdv);
    wr(`EPTB_OFS_CTRL, 32'h0);
    exp_div = int'(dl);
    tick_on = 1'b1;
    repeat (10 * int'(dl) + 20) @(posedge aclk);
    chk("tick count", 1, n_tick >= 8);
    tick_on = 1'b0;
    repeat (400) begin
      @(posedge aclk);
      ref_clk_en <= 1'($urandom);
    end
    ref_clk_en <= 1'b1;
    op(2'd2, 2'd0, 16'h0980, 8'hff, 2'd0, 1'b0);
    op(2'd3, 2'd0, 16'h0800, 8'hff, 2'd0, 1'b0);
    wait_mode <= 1'b1;
    op(2'd1, 2'd1, 16'h0000, 8'hff, 2'd0, 1'b0);
    wait_mode <= 1'b0;
    rst(4);
    rd(`EPTB_OFS_CFG); chk("cfg erased", 32'hff, rdv);
    op(2'd0, 2'd0, 16'h0800, 8'h00, 2'd1, 1'b0);
    op(2'd0, 2'd1, 16'h0000, 8'he0, 2'd0, 1'b0);
    rst(4);
    rd(`EPTB_OFS_CFG); chk("cfg secured", 32'he0, rdv);
    op(2'd2, 2'd0, 16'h0900, 8'hff, 2'd1, 1'b0);
    op(2'd3, 2'd0, 16'h0900, 8'hff, 2'd1, 1'b0);
    op(2'd0, 2'd0, 16'h08f0, 8'h00, 2'd1, 1'b0);
    op(2'd1, 2'd0, 16'h0800, 8'hff, 2'd0, 1'b1);
    op(2'd1, 2'd1, 16'h0000, 8'hff, 2'd1, 1'b0);
    rst(4);
    rd(`EPTB_OFS_CFG); chk("security kept", 0, rdv[`EPTB_SEC_BIT]);
    wr(`EPTB_OFS_DIVH, 32'h00);
    wr(`EPTB_OFS_DIVL, 32'h55);
    rd(`EPTB_OFS_DIVL); chk("divl locked", {24'h0, `EPTB_DIVL_RST}, rdv);
    wr(`EPTB_OFS_DIVH, 32'h80);
    rd(`EPTB_OFS_DIVH); chk("divh locked", 32'h00, rdv);
    op(2'd0, 2'd2, 16'h0000, 8'h00, 2'd1, 1'b0);
    rst(4);
    rd(`EPTB_OFS_DIVH); chk("divh reload", {24'h0, `EPTB_DIVH_RST}, rdv);
    op(2'd0, 2'd2, 16'h0000, 8'h00, 2'd0, 1'b0);
    rst(4);
    rd(`EPTB_OFS_DIVH); chk("lock armed", 0, rdv[`EPTB_DSEC_BIT]);
    wr(`EPTB_OFS_DIVH, 32'h80);
    rd(`EPTB_OFS_DIVH); chk("lock stays", 0, rdv[`EPTB_DSEC_BIT]);
    test_done();
  end
endmodule
